//--- src/loop_and_volume_commands.sv
// Summary of operation
// - byte 100000 plus two select bits requests repeat mode.
// - select bit 0 picks channel 1, bit 1 channel 2, both allowed.
// - accept flag of a channel stays low while it repeats.
// - repeating channel replays its phrase until cleared or stopped.
// - a stop clears that channel's repeat flag.
// - byte 100100 plus select bits releases repeat mode.
// - releasing repeat mode drives the accept flag high.
// - channel volume is two bytes, second carries 5-bit gain code.
// - channel gain code 00 is 0 dB, 1e deepest, 1f mutes.
// - channel gain codes return to 0 dB at reset and power-down.
// - master volume is byte 08 then 6-bit gain code.
// - master codes 3f..0f give gain, 0e..00 mute.
// - master gain starts at 23, kept on stop, reset on power-down.
// - accept flag low during address resolution, high when done.
`timescale 1ns/1ns
`default_nettype none
module loop_and_volume_commands #(
    parameter int NUM_CH = 2  // playback channels
) (
    input wire logic sys_clk_i,                    // 250 MHz clock
    input wire logic reset_i,                      // async, active high
    input wire logic ce_i,                         // clock enable
    // Avalon-MM slave
    input wire logic [3:0] address_i,              // byte address
    input wire logic read_i,                       // read request
    input wire logic write_i,                      // write request
    input wire logic [31:0] writedata_i,           // write data
    input wire logic [3:0] byteenable_i,           // byte lanes
    output logic [31:0] readdata_o,                // read data
    output logic waitrequest_o,                    // stall request
    // playback engine, same clock
    input wire logic [NUM_CH-1:0] play_start_i,    // play accepted
    input wire logic [NUM_CH-1:0] addr_done_i,     // address resolved
    input wire logic [NUM_CH-1:0] playing_i,       // channel playing
    input wire logic [NUM_CH-1:0] stop_i,          // stop command
    input wire logic [NUM_CH-1:0] phrase_end_i,    // phrase finished
    input wire logic power_down_i,                 // device powered down
    // results
    output logic [NUM_CH-1:0] cmd_accept_flag_o,   // accept flags
    output logic [NUM_CH-1:0] repeat_o,            // repeat flags
    output logic [NUM_CH-1:0] replay_o,            // restart phrase pulse
    output logic [4:0] chan1_gain_code_o,          // ch1 gain code
    output logic [4:0] chan2_gain_code_o,          // ch2 gain code
    output logic [NUM_CH-1:0] chan_mute_o,         // channel muted
    output logic [5:0] master_gain_code_o,         // master gain code
    output logic master_mute_o                     // master muted
);
    import loop_vol_pkg::*;

    typedef struct packed {
        logic wait_n;                  // 1 while waitrequest high
        logic [31:0] rdata;
        dec_state_e dec;
        logic [NUM_CH-1:0] dec_mask;   // channels of pending volume
        logic [NUM_CH-1:0] accept;
        logic [NUM_CH-1:0] rep;
        logic [NUM_CH-1:0] replay;
        logic [NUM_CH-1:0][4:0] cgain;
        logic [NUM_CH-1:0] cmute;
        logic [5:0] mgain;
        logic mmute;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic is_set;
    logic is_clear;
    logic is_chan_vol;
    logic is_master_vol;
    logic [1:0] chan_mask;
    logic cmd_wr;
    logic [7:0] cmd_byte;
    logic [NUM_CH-1:0] set_hit;
    logic [NUM_CH-1:0] clear_hit;
    logic [NUM_CH-1:0] channel_volume_cmd_hit;
    logic mvol_hit;

    // write takes effect at the edge where waitrequest is seen low
    assign cmd_wr = write_i && !state_reg.wait_n && ce_i
        && (address_i == CMD_OFS) && byteenable_i[0];
    assign cmd_byte = writedata_i[7:0];

    cmd_byte_classify u_classify (
        .byte_i(cmd_byte),
        .is_set_o(is_set),
        .is_clear_o(is_clear),
        .is_chan_vol_o(is_chan_vol),
        .is_master_vol_o(is_master_vol),
        .chan_mask_o(chan_mask)
    );

    // per-channel command hits; only a first byte decodes as a command
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_hit
            assign set_hit[g] = cmd_wr && state_reg.dec == DEC_IDLE
                && is_set && chan_mask[g];
            assign clear_hit[g] = cmd_wr && state_reg.dec == DEC_IDLE
                && is_clear && chan_mask[g];
            assign channel_volume_cmd_hit[g] = cmd_wr
                && state_reg.dec == DEC_CHAN_DATA
                && state_reg.dec_mask[g] && !power_down_i;
        end
    endgenerate

    // volume writes during power-down are dropped, the host must not
    // send them then, so dropping avoids a half-set gain
    assign mvol_hit = cmd_wr && state_reg.dec == DEC_MASTER_DATA
        && !power_down_i;

    // next-state logic for bus, decoder and channel state
    always_comb begin
        state_next = state_reg;
        if (ce_i) begin
            // pulse lasts one enabled cycle; a low ce_i freezes it too
            state_next.replay = '0;
            // bus: one wait cycle, then answer; read data stands with it
            if ((read_i || write_i) && state_reg.wait_n) begin
                state_next.wait_n = 1'b0;
                state_next.rdata = '0;
                unique case (address_i)
                    CMD_OFS: state_next.rdata = '0;
                    STATUS_OFS: begin
                        state_next.rdata[ST_ACCEPT_POS +: NUM_CH] =
                            state_reg.accept;
                        state_next.rdata[ST_REPEAT_POS +: NUM_CH] =
                            state_reg.rep;
                        state_next.rdata[ST_PLAYING_POS +: NUM_CH] =
                            playing_i;
                        state_next.rdata[ST_PENDING_POS] =
                            (state_reg.dec != DEC_IDLE);
                        state_next.rdata[ST_PDOWN_POS] = power_down_i;
                    end
                    CHAN_GAIN_OFS: begin
                        state_next.rdata[4:0] = state_reg.cgain[0];
                        state_next.rdata[CG_CH2_POS +: 5] =
                            state_reg.cgain[1];
                    end
                    MASTER_GAIN_OFS: state_next.rdata[5:0] = state_reg.mgain;
                    default: state_next.rdata = '0;  // unmapped reads zero
                endcase
            end else if (!state_reg.wait_n) begin
                state_next.wait_n = 1'b1;
            end

            // two-byte sequencing: first byte arms, next byte is data
            if (cmd_wr) begin
                unique case (state_reg.dec)
                    DEC_IDLE: begin
                        if (is_chan_vol) begin
                            state_next.dec = DEC_CHAN_DATA;
                            state_next.dec_mask = chan_mask;
                        end else if (is_master_vol) begin
                            state_next.dec = DEC_MASTER_DATA;
                        end
                    end
                    DEC_CHAN_DATA: state_next.dec = DEC_IDLE;
                    DEC_MASTER_DATA: state_next.dec = DEC_IDLE;
                    default: state_next.dec = DEC_IDLE;
                endcase
            end

            for (int c = 0; c < NUM_CH; c++) begin
                // repeat flag: later terms win, but a stop blocks a set
                if (stop_i[c] || clear_hit[c]) begin
                    state_next.rep[c] = 1'b0;
                end
                if (set_hit[c] && playing_i[c] && state_reg.accept[c]
                    && !stop_i[c]) begin
                    state_next.rep[c] = 1'b1;
                end
                // accept flag follows address control and repeat mode
                if (play_start_i[c]) begin
                    state_next.accept[c] = 1'b0;
                end
                if (addr_done_i[c] && !state_next.rep[c]) begin
                    state_next.accept[c] = 1'b1;
                end
                if (state_next.rep[c]) begin
                    state_next.accept[c] = 1'b0;
                end else if (state_reg.rep[c] || stop_i[c]) begin
                    state_next.accept[c] = 1'b1;
                end
                // replay the phrase, or whole edited phrase, at its end
                state_next.replay[c] = phrase_end_i[c] && state_reg.rep[c]
                    && !stop_i[c] && !clear_hit[c];
                // channel gain: 5-bit code from the data byte
                if (channel_volume_cmd_hit[c]) begin
                    state_next.cgain[c] =
                        cmd_byte[CHAN_GAIN_W-1:0];
                end
                if (power_down_i) begin
                    state_next.cgain[c] = CHAN_GAIN_INIT;
                end
                state_next.cmute[c] =
                    (state_next.cgain[c] == CHAN_GAIN_MUTE);
            end

            // master gain is kept across stop, reset on power-down
            if (mvol_hit) begin
                state_next.mgain = cmd_byte[MASTER_GAIN_W-1:0];
            end
            if (power_down_i) begin
                state_next.mgain = MASTER_GAIN_INIT;
                state_next.dec = DEC_IDLE;
            end
            state_next.mmute =
                (state_next.mgain <= MASTER_GAIN_MUTE_MAX);
        end
    end

    // one register for all state; ce_i low freezes everything
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg.wait_n <= 1'b1;
            state_reg.rdata <= '0;
            state_reg.dec <= DEC_IDLE;
            state_reg.dec_mask <= '0;
            state_reg.accept <= '1;
            state_reg.rep <= '0;
            state_reg.replay <= '0;
            state_reg.cgain <= '0;
            state_reg.cmute <= '0;
            state_reg.mgain <= MASTER_GAIN_INIT;
            state_reg.mmute <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign readdata_o = state_reg.rdata;
    assign waitrequest_o = state_reg.wait_n;
    assign cmd_accept_flag_o = state_reg.accept;
    assign repeat_o = state_reg.rep;
    assign replay_o = state_reg.replay;
    assign chan1_gain_code_o = state_reg.cgain[0];
    assign chan2_gain_code_o = state_reg.cgain[1];
    assign chan_mute_o = state_reg.cmute;
    assign master_gain_code_o = state_reg.mgain;
    assign master_mute_o = state_reg.mmute;
endmodule
`default_nettype wire

//--- src/loop_vol_pkg.sv
package loop_vol_pkg;
    // register byte offsets on the Avalon-MM slave
    localparam logic [3:0] CMD_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] CHAN_GAIN_OFS = 4'h8;
    localparam logic [3:0] MASTER_GAIN_OFS = 4'hc;
    // command byte patterns (upper six bits, or whole byte)
    localparam logic [5:0] REPEAT_SET_OP = 6'h20;   // 100000
    localparam logic [5:0] REPEAT_CLEAR_OP = 6'h24; // 100100
    localparam logic [5:0] CHAN_VOL_OP = 6'h28;     // 101000
    localparam logic [7:0] MASTER_VOL_BYTE = 8'h08; // 00001000
    // gain code widths, reset values and mute thresholds
    localparam int CHAN_GAIN_W = 5;
    localparam int MASTER_GAIN_W = 6;
    localparam logic [4:0] CHAN_GAIN_INIT = 5'h00;    // 0 dB
    localparam logic [4:0] CHAN_GAIN_MUTE = 5'h1f;
    localparam logic [5:0] MASTER_GAIN_INIT = 6'h23;  // -4.0 dB
    localparam logic [5:0] MASTER_GAIN_MUTE_MAX = 6'h0e;
    // status register field positions
    localparam int ST_ACCEPT_POS = 0;  // [1:0] accept flags
    localparam int ST_REPEAT_POS = 2;  // [3:2] repeat flags
    localparam int ST_PLAYING_POS = 4; // [5:4] playing inputs
    localparam int ST_PENDING_POS = 6; // second byte awaited
    localparam int ST_PDOWN_POS = 7;   // powered down
    // channel gain register: ch1 in [4:0], ch2 in [12:8]
    localparam int CG_CH2_POS = 8;
    // decoder state of the two-byte commands
    typedef enum logic [1:0] {
        DEC_IDLE,
        DEC_CHAN_DATA,
        DEC_MASTER_DATA
    } dec_state_e;
endpackage

//--- src/cmd_byte_classify.sv
`timescale 1ns/1ns
`default_nettype none
module cmd_byte_classify (
    input wire logic [7:0] byte_i,     // command byte, first or data byte
    output logic is_set_o,             // repeat set opcode
    output logic is_clear_o,           // repeat clear opcode
    output logic is_chan_vol_o,        // channel volume first byte
    output logic is_master_vol_o,      // master volume first byte
    output logic [1:0] chan_mask_o     // bit0 ch1, bit1 ch2
);
    import loop_vol_pkg::*;

    // pure decode, the caller decides whether a byte is a first byte
    always_comb begin
        is_set_o = (byte_i[7:2] == REPEAT_SET_OP);
        is_clear_o = (byte_i[7:2] == REPEAT_CLEAR_OP);
        is_chan_vol_o = (byte_i[7:2] == CHAN_VOL_OP);
        is_master_vol_o = (byte_i == MASTER_VOL_BYTE);
        chan_mask_o = byte_i[1:0];
    end
endmodule
`default_nettype wire

//--- verification/loop_vol_sva.sv
`timescale 1ns/1ns
`default_nettype none
module loop_vol_sva
    import loop_vol_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic write_i,
    input wire logic [1:0] play_start_i,
    input wire logic [1:0] addr_done_i,
    input wire logic [1:0] playing_i,
    input wire logic [1:0] stop_i,
    input wire logic [1:0] phrase_end_i,
    input wire logic power_down_i,
    input wire logic [1:0] cmd_accept_flag_o,
    input wire logic [1:0] repeat_o,
    input wire logic [1:0] replay_o,
    input wire logic [4:0] chan1_gain_code_o,
    input wire logic [1:0] chan_mute_o,
    input wire logic [5:0] master_gain_code_o,
    input wire logic master_mute_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // resolution done with nothing else touching channel 1
    sequence s_resolved;
        ce_i && addr_done_i[0] && !play_start_i[0] && !repeat_o[0] && !write_i;
    endsequence
    sequence s_play;
        ce_i && play_start_i[0] && !addr_done_i[0] && !stop_i[0];
    endsequence
    a_repeat_blocks: assert property (repeat_o[0] |-> !cmd_accept_flag_o[0])
        else $error("accept high while repeating");
    a_stop_clears: assert property (ce_i && stop_i[0] |=> !repeat_o[0])
        else $error("repeat kept after stop");
    // a clear landing with the phrase end releases instead of replaying
    a_replay_pulse: assert property (ce_i && repeat_o[0]
        && phrase_end_i[0] && !stop_i[0] && !write_i |=> replay_o[0])
        else $error("no replay pulse");
    a_resolve_raise: assert property (s_resolved |=> cmd_accept_flag_o[0])
        else $error("accept not raised");
    a_play_lowers: assert property (s_play |=> !cmd_accept_flag_o[0])
        else $error("accept not lowered");
    a_set_guarded: assert property ($rose(repeat_o[0]) |->
        $past(playing_i[0]) && $past(cmd_accept_flag_o[0]))
        else $error("repeat set while not allowed");
    a_pdown_init: assert property (ce_i && power_down_i |=>
        master_gain_code_o == MASTER_GAIN_INIT
        && chan1_gain_code_o == CHAN_GAIN_INIT) else $error("gain not reset");
    a_chan_mute: assert property (chan_mute_o[0] ==
        (chan1_gain_code_o == CHAN_GAIN_MUTE)) else $error("channel mute wrong");
    a_master_mute: assert property (master_mute_o ==
        (master_gain_code_o <= MASTER_GAIN_MUTE_MAX)) else $error("master mute");
endmodule
bind loop_and_volume_commands loop_vol_sva chk (.*);
`default_nettype wire

//--- verification/play_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
module play_engine_model (
    input wire logic sys_clk_i,        // clock
    input wire logic reset_i,          // async reset
    input wire logic [1:0] start_i,    // begin a phrase
    input wire logic [1:0] halt_i,     // stop request
    input wire logic [3:0] lat_i,      // resolve cycles
    output logic [1:0] play_start_o,   // play taken
    output logic [1:0] addr_done_o,    // address resolved
    output logic [1:0] playing_o,      // channel playing
    output logic [1:0] stop_o,         // stop pulse
    output logic [1:0] phrase_end_o    // phrase end pulse
);
    logic [1:0][3:0] wait_cnt;
    logic [1:0][2:0] len_cnt;
    logic [1:0] resolving;
    // slow or prompt resolve by lat_i; phrase length fixed at 8 cycles
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            {play_start_o, addr_done_o, playing_o, stop_o} <= '0;
            {phrase_end_o, resolving, wait_cnt, len_cnt} <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                play_start_o[c] <= start_i[c];
                stop_o[c] <= halt_i[c];
                addr_done_o[c] <= 1'b0;
                phrase_end_o[c] <= 1'b0;
                if (start_i[c]) begin
                    resolving[c] <= 1'b1;
                    wait_cnt[c] <= lat_i;
                end else if (resolving[c] && wait_cnt[c] == 4'h0) begin
                    addr_done_o[c] <= 1'b1;
                    resolving[c] <= 1'b0;
                    playing_o[c] <= 1'b1;
                end else if (resolving[c]) begin
                    wait_cnt[c] <= wait_cnt[c] - 4'h1;
                end
                if (playing_o[c]) begin
                    len_cnt[c] <= len_cnt[c] + 3'h1;
                    phrase_end_o[c] <= (len_cnt[c] == 3'h7);
                end
                if (halt_i[c]) begin
                    playing_o[c] <= 1'b0;
                    resolving[c] <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/loop_and_volume_commands_tb.sv
`timescale 1ns/1ns
`default_nettype none
module loop_and_volume_commands_tb;
    import loop_vol_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, rd_val;
    logic waitreq, pdown = 1'b0, mmute;
    logic [1:0] start = 2'h0, halt = 2'h0;
    logic [3:0] lat = 4'h1;
    logic [1:0] pst, adone, playing, stop, pend, accept, rep, mute;
    logic [4:0] g1, g2;
    logic [5:0] mg;
    int err_total = 0;
    int checked = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    play_engine_model eng (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .start_i(start), .halt_i(halt), .lat_i(lat), .play_start_o(pst),
        .addr_done_o(adone), .playing_o(playing), .stop_o(stop),
        .phrase_end_o(pend));
    loop_and_volume_commands dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .ce_i(1'b1), .address_i(adr), .read_i(rd), .write_i(wr),
        .writedata_i(wdata), .byteenable_i(4'hf), .readdata_o(rdata),
        .waitrequest_o(waitreq), .play_start_i(pst), .addr_done_i(adone),
        .playing_i(playing), .stop_i(stop), .phrase_end_i(pend),
        .power_down_i(pdown), .cmd_accept_flag_o(accept), .repeat_o(rep),
        .replay_o(), .chan1_gain_code_o(g1), .chan2_gain_code_o(g2),
        .chan_mute_o(mute), .master_gain_code_o(mg), .master_mute_o(mmute));
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk_i);
        adr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do @(posedge sys_clk_i); while (waitreq !== 1'b0);
        rd_val = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge sys_clk_i);
    endtask
    task automatic cmd(input logic [7:0] b);
        bus(1'b1, CMD_OFS, {24'h0, b});
    endtask
    // accept must fall on play and rise once the address is resolved
    task automatic launch(input logic [1:0] m);
        @(posedge sys_clk_i) start <= m;
        @(posedge sys_clk_i) start <= 2'h0;
        do @(negedge sys_clk_i); while ((accept & m) !== 2'h0);
        do @(negedge sys_clk_i); while ((accept & m) !== m);
    endtask
    task automatic halt_ch(input logic [1:0] m);
        @(posedge sys_clk_i) halt <= m;
        @(posedge sys_clk_i) halt <= 2'h0;
        repeat (2) @(negedge sys_clk_i);
    endtask
    task automatic t_reset();
        chk("accept", 32'h3, accept);
        chk("gain1", 32'h0, g1);
        chk("master", 32'h23, mg);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("status", 32'h3, rd_val);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, rd_val);
    endtask
    // host sets repeat only while playing with accept high
    task automatic t_repeat();
        launch(2'b11);
        cmd({REPEAT_SET_OP, 2'b11});
        chk("repeat", 32'h3, rep);
        chk("accept", 32'h0, accept);
        do @(negedge sys_clk_i); while (dut.replay_o[0] !== 1'b1);
        chk("repeat kept", 32'h3, rep);
        cmd({REPEAT_CLEAR_OP, 2'b01});
        chk("repeat", 32'h2, rep);
        chk("accept", 32'h1, accept);
        halt_ch(2'b10);
        chk("repeat", 32'h0, rep);
        halt_ch(2'b01);
    endtask
    task automatic t_ignore();
        cmd({REPEAT_SET_OP, 2'b01});
        chk("idle set", 32'h0, rep);
        lat <= 4'hf;
        @(posedge sys_clk_i) start <= 2'b01;
        @(posedge sys_clk_i) start <= 2'h0;
        do @(negedge sys_clk_i); while (accept[0] !== 1'b0);
        cmd({REPEAT_SET_OP, 2'b01});
        chk("busy set", 32'h0, rep);
        halt_ch(2'b01);
    endtask
    task automatic t_volume();
        cmd({CHAN_VOL_OP, 2'b11});
        cmd(8'h1e);
        chk("gain2", 32'h1e, g2);
        cmd({CHAN_VOL_OP, 2'b01});
        cmd(8'h1f);
        chk("mute", 32'h1, mute);
        bus(1'b0, CHAN_GAIN_OFS, 32'h0);
        chk("chan gains", 32'h1e1f, rd_val);
        cmd(MASTER_VOL_BYTE);
        cmd(8'h3f);
        chk("master", 32'h3f, mg);
        cmd(MASTER_VOL_BYTE);
        cmd(8'h0e);
        chk("master mute", 32'h1, mmute);
        bus(1'b1, MASTER_GAIN_OFS, 32'h3f);
        halt_ch(2'b01);
        chk("master kept", 32'h0e, mg);
        // no volume bytes are sent while powered down
        @(posedge sys_clk_i) pdown <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        pdown <= 1'b0;
        @(negedge sys_clk_i);
        chk("master init", 32'h23, mg);
        chk("gain2 init", 32'h0, g2);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // a hang of the bus or engine ends the run
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(negedge sys_clk_i);
        t_reset();
        t_repeat();
        t_ignore();
        t_volume();
        end_of_test();
    end
endmodule
`default_nettype wire
